// ==== design/led_regs_pkg.sv ====
package led_regs_pkg;

  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_RATIO_HI = 8'h02;
  localparam logic [7:0] ADDR_RATIO_LO = 8'h03;
  localparam logic [7:0] ADDR_ONOFF_HI = 8'h04;
  localparam logic [7:0] ADDR_ONOFF_LO = 8'h05;
  localparam logic [7:0] ADDR_OUT1_CTL = 8'h06;
  localparam logic [7:0] ADDR_OUT2_CTL = 8'h07;
  localparam logic [7:0] REG_COUNT = 8'h08;

  // ******************************************************
  // Field positions
  // ******************************************************
  localparam int CHIP_EN_POS = 6;
  localparam int ENG1_POS = 4;
  localparam int ENG2_POS = 2;
  localparam int ENG3_POS = 0;
  localparam int MAP_POS = 6;
  localparam int LOG_POS = 5;
  localparam int TEMP_POS = 0;

  // ******************************************************
  // Writable bits and reset values
  // ******************************************************
  localparam logic [7:0] MASK_ENABLE = 8'h7f;
  localparam logic [7:0] MASK_MODE = 8'h3f;
  localparam logic [7:0] MASK_SINGLE = 8'h01;
  localparam logic [7:0] MASK_FULL = 8'hff;
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_RATIO = 8'h00;
  localparam logic [7:0] RST_ONOFF_HI = 8'h01;
  localparam logic [7:0] RST_ONOFF_LO = 8'hff;
  localparam logic [7:0] RST_OUT_CTL = 8'h00;

  // ******************************************************
  // Serial link
  // ******************************************************
  localparam logic [6:0] DEV_ADDR_BASE = 7'h30;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_PRE = 4'hf;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_PTR = 3'b010,
    S_WDATA = 3'b011,
    S_RDATA = 3'b100
  } xfer_state_t;

  function automatic logic [7:0] reg_mask(input logic [2:0] idx);
    case (idx)
      3'h0: reg_mask = MASK_ENABLE;
      3'h1: reg_mask = MASK_MODE;
      3'h2: reg_mask = MASK_SINGLE;
      3'h4: reg_mask = MASK_SINGLE;
      default: reg_mask = MASK_FULL;
    endcase
  endfunction

  function automatic logic [7:0] reg_reset(input logic [2:0] idx);
    case (idx)
      3'h0: reg_reset = RST_ENABLE;
      3'h1: reg_reset = RST_MODE;
      3'h4: reg_reset = RST_ONOFF_HI;
      3'h5: reg_reset = RST_ONOFF_LO;
      3'h6: reg_reset = RST_OUT_CTL;
      3'h7: reg_reset = RST_OUT_CTL;
      default: reg_reset = RST_RATIO;
    endcase
  endfunction

endpackage

// ==== design/byte_link_if.sv ====
`timescale 1ns/1ps
interface byte_link_if;
  logic rx_done;
  logic [7:0] rx_byte;
  logic ack_done;
  logic master_ack;
  logic ack_req;
  logic tx_mode;
  logic [7:0] tx_byte;
  logic frame_start;
  logic frame_stop;
  modport phy(output rx_done, rx_byte, ack_done, master_ack, frame_start, frame_stop,
              input ack_req, tx_mode, tx_byte);
  modport ctrl(input rx_done, rx_byte, ack_done, master_ack, frame_start, frame_stop,
               output ack_req, tx_mode, tx_byte);
endinterface

// ==== design/serial_bit_engine.sv ====
`timescale 1ns/1ps
module serial_bit_engine
  import led_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  byte_link_if.phy link
);

  logic scl_q, sda_q, active_q, tx_q, oe_q, rx_done_q, ack_done_q, mack_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, rx_byte_q;

  // ******************************************************
  // Line events
  // ******************************************************
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_seen = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_seen = scl_in & scl_q & ~sda_q & sda_in;
  wire [3:0] cnt_next = (cnt_q == BIT_ACK || cnt_q == BIT_PRE) ? 4'h0 : cnt_q + 4'h1;
  wire tx_now = (cnt_next == 4'h0) ? link.tx_mode : tx_q;
  wire tx_bit = link.tx_byte[3'(BIT_LAST - cnt_next)];
  // Only ever pulls low; ack is withheld while the master owns the ack slot
  wire drive_next = (cnt_next == BIT_ACK) ? (link.ack_req & ~tx_q) : (tx_now & ~tx_bit);
  wire rx_last = active_q & scl_rise & ~tx_q & (cnt_q == BIT_LAST);
  wire ack_seen = active_q & scl_rise & tx_q & (cnt_q == BIT_ACK);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
    end
  end

  // ******************************************************
  // Frame and bit position
  // ******************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      cnt_q <= BIT_PRE;
      tx_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (start_seen) begin
      active_q <= 1'b1;
      cnt_q <= BIT_PRE;
      tx_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (stop_seen) begin
      active_q <= 1'b0;
      oe_q <= 1'b0;
    end else if (active_q & scl_fall) begin
      cnt_q <= cnt_next;
      tx_q <= tx_now;
      oe_q <= drive_next;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= 8'h00;
      rx_byte_q <= 8'h00;
      rx_done_q <= 1'b0;
      ack_done_q <= 1'b0;
      mack_q <= 1'b0;
    end else begin
      if (active_q & scl_rise & (cnt_q < BIT_ACK)) begin
        shift_q <= {shift_q[6:0], sda_in};
      end
      if (rx_last) begin
        rx_byte_q <= {shift_q[6:0], sda_in};
      end
      if (ack_seen) begin
        mack_q <= ~sda_in;
      end
      rx_done_q <= rx_last;
      ack_done_q <= ack_seen;
    end
  end

  assign link.rx_done = rx_done_q;
  assign link.rx_byte = rx_byte_q;
  assign link.ack_done = ack_done_q;
  assign link.master_ack = mack_q;
  // Frame edges travel on the link so the sequencer never reaches into this module
  assign link.frame_start = start_seen;
  assign link.frame_stop = stop_seen;
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

endmodule // serial_bit_engine

// ==== design/led_driver_control_regs_low.sv ====
// Operation
// RULE1 - Settings live in byte registers, reached only over the two-wire serial port.
// RULE2 - Address 00 bit 6 is chip enable, reset 0, write 1 enables.
// RULE3 - Address 00 holds engine run fields at [5:4],[3:2],[1:0], reset 00.
// RULE4 - Address 01 holds engine mode fields at [5:4],[3:2],[1:0], reset 00.
// RULE5 - Ratiometric enables: output nine at 02 bit0, outputs eight..one at 03; reset 0.
// RULE6 - On/off bits: output nine at 04 bit0, outputs eight..one at 05; reset 1.
// RULE7 - Output one (06) and two (07) controls hold mapping at [7:6], reset 00.
// RULE8 - Bit 5 of each output control selects logarithmic dimming, reset 0.
// RULE9 - Bits [4:0] of each output control are temperature compensation, reset 0.
// RULE10 - Bits without a function are reserved; host must not rely on them.
// RULE11 - Reserved bits read as zero and writes to them are ignored.
`timescale 1ns/1ps
module led_driver_control_regs_low
  import led_regs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_sel,
  output logic chip_enable,
  output logic [1:0] engine_one_run_field,
  output logic [1:0] engine_two_run_field,
  output logic [1:0] engine_three_run_field,
  output logic [1:0] engine_one_mode_field,
  output logic [1:0] engine_two_mode_field,
  output logic [1:0] engine_three_mode_field,
  output logic [8:0] ratio_enable,
  output logic [8:0] output_on,
  output logic [1:0] output_one_mapping,
  output logic output_one_log,
  output logic [4:0] output_one_temp,
  output logic [1:0] output_two_mapping,
  output logic output_two_log,
  output logic [4:0] output_two_temp
);

  byte_link_if link ();

  serial_bit_engine u_phy (
    .clock(clock),
    .rst_n(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .link(link.phy)
  );

  xfer_state_t state_q;
  logic [7:0] ptr_q, tx_byte_q;
  logic ack_req_q, tx_mode_q;
  logic [7:0] regs_q [0:7];

  // ******************************************************
  // Transfer decode
  // ******************************************************
  wire addr_hit = link.rx_byte[7:1] == {DEV_ADDR_BASE[6:2], addr_sel};
  wire rx_addr = link.rx_done && (state_q == S_ADDR);
  wire rx_ptr = link.rx_done && (state_q == S_PTR);
  wire wr_fire = link.rx_done && (state_q == S_WDATA);
  wire rd_ack = link.ack_done && (state_q == S_RDATA);
  wire rd_start = rx_addr && addr_hit && link.rx_byte[0];
  wire rd_load = rd_start || (rd_ack && link.master_ack);
  wire [7:0] rd_ptr = (state_q == S_RDATA) ? ptr_q + 8'h01 : ptr_q;
  wire wr_mapped = wr_fire && (ptr_q < REG_COUNT);
  // Unmapped addresses read zero so the host never sees stale data
  wire [7:0] rd_data = (rd_ptr < REG_COUNT) ? regs_q[rd_ptr[2:0]] : 8'h00; // [RULE11]

  // ******************************************************
  // Transfer sequencer
  // ******************************************************
  // A repeated start re-arms address matching without a stop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ack_req_q <= 1'b0;
      tx_mode_q <= 1'b0;
    end else if (link.rx_done || link.ack_done) begin
      unique case (state_q)
        S_ADDR: begin
          state_q <= !addr_hit ? S_IDLE : (link.rx_byte[0] ? S_RDATA : S_PTR); // [RULE1]
          ack_req_q <= addr_hit;
          tx_mode_q <= addr_hit && link.rx_byte[0];
        end
        S_PTR: state_q <= S_WDATA;
        S_RDATA: begin
          state_q <= (rd_ack && !link.master_ack) ? S_IDLE : S_RDATA;
          tx_mode_q <= !(rd_ack && !link.master_ack);
        end
        S_IDLE, S_WDATA: state_q <= state_q;
      endcase
    end else if (link.frame_start) begin
      state_q <= S_ADDR;
      ack_req_q <= 1'b0;
      tx_mode_q <= 1'b0;
    end else if (link.frame_stop) begin
      state_q <= S_IDLE;
      tx_mode_q <= 1'b0;
    end
  end

  // Pointer auto-increments after every data byte moved in either direction
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
      tx_byte_q <= 8'h00;
    end else begin
      if (rx_ptr) begin
        ptr_q <= link.rx_byte;
      end else if (wr_fire || rd_ack) begin
        ptr_q <= ptr_q + 8'h01;
      end
      if (rd_load) begin
        tx_byte_q <= rd_data; // [RULE1]
      end
    end
  end

  assign link.ack_req = ack_req_q;
  assign link.tx_mode = tx_mode_q;
  assign link.tx_byte = tx_byte_q;

  // ******************************************************
  // Register storage
  // ******************************************************
  // Masking at write time keeps reserved bits zero for free on readback
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= reg_reset(3'(i)); // [RULE2] [RULE3] [RULE4] [RULE5] [RULE6] [RULE7] [RULE8] [RULE9]
      end
    end else if (wr_mapped) begin
      regs_q[ptr_q[2:0]] <= link.rx_byte & reg_mask(ptr_q[2:0]); // [RULE10] [RULE11]
    end
  end

  assign chip_enable = regs_q[0][CHIP_EN_POS]; // [RULE2]
  assign engine_one_run_field = regs_q[0][ENG1_POS +: 2]; // [RULE3]
  assign engine_two_run_field = regs_q[0][ENG2_POS +: 2]; // [RULE3]
  assign engine_three_run_field = regs_q[0][ENG3_POS +: 2]; // [RULE3]
  assign engine_one_mode_field = regs_q[1][ENG1_POS +: 2]; // [RULE4]
  assign engine_two_mode_field = regs_q[1][ENG2_POS +: 2]; // [RULE4]
  assign engine_three_mode_field = regs_q[1][ENG3_POS +: 2]; // [RULE4]
  assign ratio_enable = {regs_q[2][0], regs_q[3]}; // [RULE5]
  assign output_on = {regs_q[4][0], regs_q[5]}; // [RULE6]
  assign output_one_mapping = regs_q[6][MAP_POS +: 2]; // [RULE7]
  assign output_one_log = regs_q[6][LOG_POS]; // [RULE8]
  assign output_one_temp = regs_q[6][TEMP_POS +: 5]; // [RULE9]
  assign output_two_mapping = regs_q[7][MAP_POS +: 2]; // [RULE7]
  assign output_two_log = regs_q[7][LOG_POS]; // [RULE8]
  assign output_two_temp = regs_q[7][TEMP_POS +: 5]; // [RULE9]

  // ******************************************************
  // Assertions
  // ******************************************************
  wire [63:0] reg_image = {regs_q[0], regs_q[1], regs_q[2], regs_q[3], regs_q[4], regs_q[5], regs_q[6], regs_q[7]};

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  property p_addr_ack;
    rx_addr && addr_hit |=> link.ack_req ##1 (state_q != S_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("Own address not acknowledged"); // [RULE1]

  property p_chip_enable;
    wr_fire && ptr_q == ADDR_ENABLE |=> chip_enable == $past(link.rx_byte[CHIP_EN_POS]);
  endproperty
  a_chip_enable: assert property (p_chip_enable) else $error("Chip enable not written"); // [RULE2]

  property p_run_hold;
    !(wr_fire && ptr_q == ADDR_ENABLE)
      |=> $stable({engine_one_run_field, engine_two_run_field, engine_three_run_field});
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("Run field changed without write"); // [RULE3]

  property p_mode_write;
    wr_fire && ptr_q == ADDR_MODE
      |=> {engine_one_mode_field, engine_two_mode_field, engine_three_mode_field} == $past(link.rx_byte[5:0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("Mode fields not written"); // [RULE4]

  property p_ratio_high;
    wr_fire && ptr_q == ADDR_RATIO_HI |=> ratio_enable[8] == $past(link.rx_byte[0]) && $stable(ratio_enable[7:0]);
  endproperty
  a_ratio_high: assert property (p_ratio_high) else $error("Output nine ratio bit wrong"); // [RULE5]

  property p_onoff_low;
    wr_fire && ptr_q == ADDR_ONOFF_LO |=> output_on[7:0] == $past(link.rx_byte) && $stable(output_on[8]);
  endproperty
  a_onoff_low: assert property (p_onoff_low) else $error("On/off bits wrong"); // [RULE6]

  property p_map_write;
    wr_fire && ptr_q == ADDR_OUT2_CTL |=> output_two_mapping == $past(link.rx_byte[7:6]) && $stable(output_one_mapping);
  endproperty
  a_map_write: assert property (p_map_write) else $error("Mapping field wrong"); // [RULE7]

  property p_log_write;
    wr_fire && ptr_q == ADDR_OUT1_CTL |=> output_one_log == $past(link.rx_byte[LOG_POS]);
  endproperty
  a_log_write: assert property (p_log_write) else $error("Log dimming bit wrong"); // [RULE8]

  property p_temp_write;
    wr_fire && ptr_q == ADDR_OUT1_CTL |=> output_one_temp == $past(link.rx_byte[4:0]);
  endproperty
  a_temp_write: assert property (p_temp_write) else $error("Temperature field wrong"); // [RULE9]

  property p_reserved_read;
    rd_load && rd_ptr == ADDR_ENABLE |=> tx_byte_q[7] == 1'b0;
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("Reserved bit read nonzero"); // [RULE10]

  property p_unmapped_write;
    wr_fire && ptr_q >= REG_COUNT |=> $stable(reg_image) ##1 $stable(reg_image);
  endproperty
  a_unmapped_write: assert property (p_unmapped_write) else $error("Unmapped write changed registers"); // [RULE11]

  c_write_enable: cover property (wr_fire && ptr_q == ADDR_ENABLE);
  c_read_burst: cover property (rd_ack && link.master_ack);
  c_read_end: cover property (rd_ack && !link.master_ack);
  c_addr_miss: cover property (rx_addr && !addr_hit);

endmodule // led_driver_control_regs_low

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic host_low
);
  // ******************************************************
  // Bus master, all changes on the falling edge
  // ******************************************************
  initial begin
    scl = 1'b1;
    host_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask

  // Also serves as repeated start: data is released before scl rises
  task automatic start_cond();
    host_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    host_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic stop_cond();
    host_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    host_low = 1'b0;
    tick(4);
  endtask

  // Four clocks high and low, above the slave's two-clock minimum high time
  task automatic bit_io(input logic b, output logic r);
    host_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda_line;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask

  task automatic byte_out(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, r);
  endtask

  // Registers are only reached through these serial frames
  task automatic write_seq(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] data[$], output logic ok);
    logic a;
    start_cond();
    byte_out({dev, 1'b0}, ok);
    byte_out(ptr, a);
    ok &= a;
    foreach (data[k]) begin
      byte_out(data[k], a);
      ok &= a;
    end
    stop_cond();
  endtask

  task automatic read_seq(input logic [6:0] dev, input logic [7:0] ptr, input int n, output logic [7:0] q[$],
                          output logic ok);
    logic a;
    logic [7:0] b;
    q = {};
    start_cond();
    byte_out({dev, 1'b0}, ok);
    byte_out(ptr, a);
    ok &= a;
    start_cond();
    byte_out({dev, 1'b1}, a);
    ok &= a;
    for (int k = 0; k < n; k++) begin
      byte_in(k == n - 1, b);
      q.push_back(b);
    end
    stop_cond();
  endtask
endmodule // host_model

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
  import led_regs_pkg::*;
  logic clock, rst_n, sda_line, scl, host_low, sda_out, sda_oe, chip_enable, ok;
  logic [1:0] addr_sel, e1r, e2r, e3r, e1m, e2m, e3m, map1, map2;
  logic [8:0] ratio_enable, output_on;
  logic log1, log2;
  logic [4:0] temp1, temp2;
  logic [7:0] q[$];
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] rst_tab [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'h00};
  logic [7:0] mask_tab [8] = '{8'h7f, 8'h3f, 8'h01, 8'hff, 8'h01, 8'hff, 8'hff, 8'hff};
  logic [6:0] own_addr;

  assign own_addr = {DEV_ADDR_BASE[6:2], 2'b10};
  // Open drain with pull-up: low when either party pulls
  assign sda_line = ~(host_low | (sda_oe & ~sda_out));

  led_driver_control_regs_low uut (.clock(clock), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel), .chip_enable(chip_enable),
    .engine_one_run_field(e1r), .engine_two_run_field(e2r), .engine_three_run_field(e3r),
    .engine_one_mode_field(e1m), .engine_two_mode_field(e2m), .engine_three_mode_field(e3m),
    .ratio_enable(ratio_enable), .output_on(output_on), .output_one_mapping(map1), .output_one_log(log1),
    .output_one_temp(temp1), .output_two_mapping(map2), .output_two_log(log2), .output_two_temp(temp2));

  host_model host (.clock(clock), .sda_line(sda_line), .scl(scl), .host_low(host_low));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ******************************************************
  // Checking
  // ******************************************************
  function automatic logic [7:0] obs(input int i);
    case (i)
      0: obs = {1'b0, chip_enable, e1r, e2r, e3r};
      1: obs = {2'b00, e1m, e2m, e3m};
      2: obs = {7'h00, ratio_enable[8]};
      3: obs = ratio_enable[7:0];
      4: obs = {7'h00, output_on[8]};
      5: obs = output_on[7:0];
      6: obs = {map1, log1, temp1};
      default: obs = {map2, log2, temp2};
    endcase
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      give_verdict();
    end
  end

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic t_reset_values();
    host.read_seq(own_addr, 8'h00, 8, q, ok);
    check({7'h0, ok}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      check(q[i], rst_tab[i]);
      check(obs(i), rst_tab[i]);
    end
    $display("test reset_values done");
  endtask

  // Burst write then burst read; reserved bits must come back clear
  task automatic t_write_read();
    logic [7:0] pats [3] = '{8'hff, 8'h5a, 8'ha5};
    foreach (pats[p]) begin
      host.write_seq(own_addr, 8'h00, '{pats[p], pats[p], pats[p], pats[p], pats[p], pats[p], pats[p], pats[p]}, ok);
      check({7'h0, ok}, 8'h01);
      check({7'h0, chip_enable}, {7'h0, pats[p][6]});
      host.read_seq(own_addr, 8'h00, 8, q, ok);
      for (int i = 0; i < 8; i++) begin
        check(q[i], pats[p] & mask_tab[i]);
        check(obs(i), pats[p] & mask_tab[i]);
      end
    end
    $display("test write_read done");
  endtask

  task automatic t_unmapped();
    host.write_seq(own_addr, 8'h08, '{8'hff}, ok);
    check({7'h0, ok}, 8'h01);
    host.read_seq(own_addr, 8'h07, 2, q, ok);
    check(q[0], 8'ha5);
    check(q[1], 8'h00);
    $display("test unmapped done");
  endtask

  task automatic t_wrong_addr();
    host.write_seq({DEV_ADDR_BASE[6:2], 2'b01}, 8'h00, '{8'h40}, ok);
    check({7'h0, ok}, 8'h00);
    check({7'h0, chip_enable}, 8'h00);
    // Same frame once the select pins point at it: now it must land
    addr_sel = 2'b01;
    host.write_seq({DEV_ADDR_BASE[6:2], 2'b01}, 8'h00, '{8'h40}, ok);
    check({7'h0, ok}, 8'h01);
    check({7'h0, chip_enable}, 8'h01);
    addr_sel = 2'b10;
    $display("test wrong_addr done");
  endtask

  task automatic t_rereset();
    rst_n = 1'b0;
    @(negedge clock);
    for (int i = 0; i < 8; i++) begin
      check(obs(i), rst_tab[i]);
    end
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_reset_values();
    $display("test rereset done");
  endtask

  initial begin
    rst_n = 1'b0;
    addr_sel = 2'b10;
    repeat (10) @(negedge clock);
    rst_n = 1'b1;
    repeat (3) @(negedge clock);
    t_reset_values();
    t_write_read();
    t_unmapped();
    t_wrong_addr();
    t_rereset();
    give_verdict();
  end
endmodule // tb
